/* File: abx_pkg.sv */
// Package: encodings, widths and constants for the arithmetic/bit/branch executor
package abx_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 15;
  localparam int INSTR_W = 14;
  localparam int OFFS_W = 9;
  localparam int BITSEL_W = 3;
  // Opcode fields (upper bits of the 14-bit word)
  localparam logic [5:0] OP_ADD_WORK_TO_REG = 6'h07;
  localparam logic [5:0] OP_ADD_WORK_CARRY_TO_REG = 6'h3D;
  localparam logic [5:0] OP_ARITH_SHIFT_RIGHT = 6'h37;
  localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OP_SKIP_IF_BIT_CLEAR = 4'h6;
  localparam logic [4:0] OP_RELATIVE_BRANCH = 5'h19;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] NIBBLE_MAX = 4'hF;
  // Field positions
  localparam int DEST_BIT = 7;
  localparam int BITSEL_LSB = 7;
  localparam int MSB_POS = 7;
  // Cycle counts
  localparam int SINGLE_CYCLES = 1;
  localparam int FLUSH_CYCLES = 2;
  typedef enum logic [2:0] {
    ABX_NONE, ABX_ADD, ABX_ADDC, ABX_ASR, ABX_BCLR, ABX_SKIPC, ABX_BRA
  } abx_kind_t;
endpackage

/* File: abx_alu.sv */
// Arithmetic unit: adds with carry and digit carry, shift, bit clear
`timescale 1ns/1ps
module abx_alu (
  input wire logic [7:0] work,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire abx_pkg::abx_kind_t kind,
  input wire logic [2:0] bit_sel,
  output logic [7:0] result,
  output logic carry_out,
  output logic digit_carry_out,
  output logic zero_out
);
  // ------------------------------------------------------------
  // Adders
  // ------------------------------------------------------------
  wire logic cin;
  wire logic [4:0] low_sum;
  wire logic [8:0] full_sum;
  wire logic [7:0] clr_mask;
  assign cin = (kind == abx_pkg::ABX_ADDC) ? carry_in : 1'b0;
  // Low nibble sum gives the digit carry
  assign low_sum = {1'b0, work[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
  assign full_sum = {1'b0, work} + {1'b0, operand} + {8'h00, cin};
  assign clr_mask = ~(8'h01 << bit_sel);

  // ------------------------------------------------------------
  // Result select
  // ------------------------------------------------------------
  always_comb
  begin
    result = operand;
    carry_out = carry_in;
    digit_carry_out = 1'b0;
    case (kind)
      abx_pkg::ABX_ADD, abx_pkg::ABX_ADDC:
      begin
        result = full_sum[7:0]; // [RQ1] [RQ2]
        carry_out = full_sum[8];
        digit_carry_out = low_sum[4];
      end
      abx_pkg::ABX_ASR:
      begin
        result = {operand[abx_pkg::MSB_POS], operand[7:1]}; // [RQ3]
        carry_out = operand[0];
      end
      abx_pkg::ABX_BCLR:
        result = operand & clr_mask; // [RQ4]
      default:
        result = operand;
    endcase
  end
  assign zero_out = (result == abx_pkg::ZERO_BYTE);
endmodule

/* File: abx_exec.sv */
// Executor for add, add-with-carry, shift, bit clear, skip and relative branch
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Add work and location; destination bit selects target
// RQ2: Add work, location, carry; same destination choice
// RQ3: Shift right keeping msb; bit0 into carry
// RQ4: Clear chosen bit; flags untouched
// RQ5: Bit zero discards next instruction, two cycles
// RQ6: Branch to address plus one plus offset
// RQ7: Branch takes two cycles
// RQ8: Program counter change adds a no-operation cycle
// RQ9: Non-branching operations finish in one cycle
module abx_exec (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_addr_q,
  output logic [7:0] file_wdata_q,
  output logic file_we_q,
  output logic [7:0] work_q,
  output logic carry_q,
  output logic digit_carry_flag_q,
  output logic zero_q,
  output logic [14:0] program_counter_q,
  output logic flush_q
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  abx_pkg::abx_kind_t kind;
  wire logic live;
  wire logic dest_reg;
  wire logic [2:0] bit_sel;
  wire logic [8:0] offset;
  wire logic [7:0] alu_res;
  wire logic alu_c;
  wire logic alu_dc;
  wire logic alu_z;
  wire logic bit_is_zero;
  wire logic [14:0] pc_inc;
  wire logic [14:0] pc_branch;
  // An instruction arriving in the flush cycle executes as a no-operation
  assign live = instr_valid && !flush_q; // [RQ8]
  always_comb
  begin
    kind = abx_pkg::ABX_NONE;
    if (!live)
      kind = abx_pkg::ABX_NONE;
    else if (instr[13:8] == abx_pkg::OP_ADD_WORK_TO_REG)
      kind = abx_pkg::ABX_ADD;
    else if (instr[13:8] == abx_pkg::OP_ADD_WORK_CARRY_TO_REG)
      kind = abx_pkg::ABX_ADDC;
    else if (instr[13:8] == abx_pkg::OP_ARITH_SHIFT_RIGHT)
      kind = abx_pkg::ABX_ASR;
    else if (instr[13:10] == abx_pkg::OP_BIT_CLEAR)
      kind = abx_pkg::ABX_BCLR;
    else if (instr[13:10] == abx_pkg::OP_SKIP_IF_BIT_CLEAR)
      kind = abx_pkg::ABX_SKIPC;
    else if (instr[13:9] == abx_pkg::OP_RELATIVE_BRANCH)
      kind = abx_pkg::ABX_BRA;
    else
      kind = abx_pkg::ABX_NONE;
  end
  assign dest_reg = instr[abx_pkg::DEST_BIT];
  assign bit_sel = instr[abx_pkg::BITSEL_LSB +: abx_pkg::BITSEL_W];
  assign offset = instr[8:0];
  assign bit_is_zero = !file_rdata[bit_sel];
  // Program counter still holds the branch's own address when it executes
  assign pc_inc = program_counter_q + abx_pkg::PC_ONE;
  assign pc_branch = pc_inc + {{6{offset[8]}}, offset}; // [RQ6]

  abx_alu u_alu (
    .work(work_q),
    .operand(file_rdata),
    .carry_in(carry_q),
    .kind(kind),
    .bit_sel(bit_sel),
    .result(alu_res),
    .carry_out(alu_c),
    .digit_carry_out(alu_dc),
    .zero_out(alu_z)
  );

  wire logic is_arith;
  wire logic writes_reg;
  wire logic takes_flush;
  assign is_arith = (kind == abx_pkg::ABX_ADD) || (kind == abx_pkg::ABX_ADDC)
    || (kind == abx_pkg::ABX_ASR);
  assign writes_reg = (is_arith && dest_reg) || (kind == abx_pkg::ABX_BCLR);
  // Taken skip and branch both burn the next slot
  assign takes_flush = (kind == abx_pkg::ABX_BRA)
    || ((kind == abx_pkg::ABX_SKIPC) && bit_is_zero); // [RQ5] [RQ7]

  // ------------------------------------------------------------
  // State update, one instruction per cycle
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      work_q <= abx_pkg::ZERO_BYTE;
      carry_q <= 1'b0;
      digit_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
      file_addr_q <= 7'h00;
      file_wdata_q <= abx_pkg::ZERO_BYTE;
      file_we_q <= 1'b0;
      program_counter_q <= abx_pkg::PC_RESET;
      flush_q <= 1'b0;
    end
    else
    begin
      file_we_q <= writes_reg; // [RQ1] [RQ9]
      file_addr_q <= instr[6:0];
      file_wdata_q <= alu_res;
      flush_q <= takes_flush; // [RQ8]
      if (is_arith && !dest_reg)
        work_q <= alu_res;
      if (is_arith)
      begin
        carry_q <= alu_c; // [RQ3]
        zero_q <= alu_z;
      end
      if ((kind == abx_pkg::ABX_ADD) || (kind == abx_pkg::ABX_ADDC))
        digit_carry_flag_q <= alu_dc; // [RQ2]
      if (instr_valid)
        program_counter_q <= (kind == abx_pkg::ABX_BRA) ? pc_branch : pc_inc;
    end
  end

  // ------------------------------------------------------------
  // Checks on arithmetic, shift and bit clear
  // ------------------------------------------------------------
  // Add to work leaves the file untouched
  add_dest_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ1]
    (kind == abx_pkg::ABX_ADD && !dest_reg) |=>
      (work_q == 8'($past(work_q) + $past(file_rdata)) && !file_we_q))
    else $error("add to work wrong");
  // Flags recomputed from the operands, not read back from the adder
  add_flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ1]
    (kind == abx_pkg::ABX_ADD) |=>
      (carry_q == (({1'b0, $past(work_q)} + {1'b0, $past(file_rdata)}) > 9'h0FF)
      && digit_carry_flag_q == (({1'b0, $past(work_q[3:0])}
        + {1'b0, $past(file_rdata[3:0])}) > {1'b0, abx_pkg::NIBBLE_MAX})
      && zero_q == (8'($past(work_q) + $past(file_rdata)) == abx_pkg::ZERO_BYTE)))
    else $error("add flags wrong");
  // Carry in from the flag; the ninth bit must land in carry
  addc_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ2]
    (kind == abx_pkg::ABX_ADDC && dest_reg) |=>
      ({carry_q, file_wdata_q} == {1'b0, $past(work_q)} + {1'b0, $past(file_rdata)}
        + {8'h00, $past(carry_q)}) && file_we_q)
    else $error("add with carry wrong");
  // Result to work, file write held off
  addc_work_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ2]
    (kind == abx_pkg::ABX_ADDC && !dest_reg) |=>
      (work_q == 8'($past(work_q) + $past(file_rdata) + {7'h00, $past(carry_q)})
      && !file_we_q))
    else $error("add with carry to work wrong");
  // Msb kept, low bit leaves through carry
  asr_shape_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ3]
    (kind == abx_pkg::ABX_ASR) |=> (carry_q == $past(file_rdata[0])
      && file_wdata_q[7] == $past(file_rdata[7])))
    else $error("shift wrong");
  // Shift back to the file keeps work as it was
  asr_dest_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ3]
    (kind == abx_pkg::ABX_ASR && dest_reg) |=> (file_we_q && $stable(work_q)
      && file_wdata_q[6:0] == $past(file_rdata[7:1])))
    else $error("shift to file wrong");
  // Flags must survive a bit clear
  bclr_flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ4]
    (kind == abx_pkg::ABX_BCLR) |=> (file_we_q && $stable(carry_q) && $stable(zero_q)
      && !file_wdata_q[$past(bit_sel)]))
    else $error("bit clear wrong");
  // Write goes back to the location that was read
  bclr_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ4]
    (kind == abx_pkg::ABX_BCLR) |=> (file_addr_q == $past(instr[6:0])
      && $stable(work_q) && $stable(digit_carry_flag_q)))
    else $error("bit clear address wrong");
  // No stall for straight-line work
  single_cycle_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ9]
    (is_arith || kind == abx_pkg::ABX_BCLR) |=> !flush_q)
    else $error("single cycle op stalled");

  // ------------------------------------------------------------
  // Checks on skip, branch and the discarded slot
  // ------------------------------------------------------------
  // Target is relative to the already advanced counter
  branch_target_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ6]
    (kind == abx_pkg::ABX_BRA) |=> (program_counter_q == $past(pc_branch)))
    else $error("branch target wrong");
  // Exactly one slot is burnt, never two
  branch_flush_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ7]
    (kind == abx_pkg::ABX_BRA) |=> flush_q ##1 !flush_q)
    else $error("branch did not flush one slot");
  // Branch touches neither work, file nor flags
  branch_flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ6]
    (kind == abx_pkg::ABX_BRA) |=> (!file_we_q && $stable(work_q) && $stable(carry_q)
      && $stable(digit_carry_flag_q) && $stable(zero_q)))
    else $error("branch changed state");
  // Clear bit means the next slot is thrown away
  skip_taken_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ5]
    (kind == abx_pkg::ABX_SKIPC && bit_is_zero) |=> flush_q)
    else $error("skip not taken");
  // Set bit lets the next instruction run
  skip_not_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ5]
    (kind == abx_pkg::ABX_SKIPC && !bit_is_zero) |=> !flush_q)
    else $error("skip taken on set bit");
  // A skip only tests; nothing is written
  skip_flags_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ5]
    (kind == abx_pkg::ABX_SKIPC) |=> (!file_we_q && $stable(work_q) && $stable(carry_q)
      && $stable(digit_carry_flag_q) && $stable(zero_q)))
    else $error("skip changed state");
  // Discarded slot behaves as a no-operation
  flush_nop_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ8]
    flush_q |=> (!file_we_q && $stable(work_q) && $stable(carry_q)))
    else $error("flush cycle did work");
  // A discarded slot still moves the counter by one
  flush_pc_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ8]
    (flush_q && instr_valid) |=>
      (program_counter_q == 15'($past(program_counter_q) + abx_pkg::PC_ONE)))
    else $error("flush slot lost its count");
endmodule

/* File: abx_file_model.sv */
// Data-file model: same-cycle reads, writes taken at the clock edge
`timescale 1ns/1ps
module abx_file_model (
  input wire logic sys_clk,
  input wire logic [6:0] rd_addr,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  output logic [7:0] rd_data
);
  logic [7:0] mem [128];
  // Preload: odd locations carry the msb so the shift sees it set
  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = {i[0], i[6:0]};
    end
  end
  // Pending write is forwarded, else a back-to-back read sees stale data
  assign rd_data = (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
  // Write port
  always @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule

/* File: abx_exec_tb.sv */
// Self-checking bench for the executor with a data-file model beside it
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module arith_bit_branch_executor_tb_top;
  typedef struct {logic [13:0] op; logic [7:0] w; logic [3:0] f; logic [7:0] wd;} abx_row_t;
  logic sys_clk, sys_rst, instr_valid, file_we_q, carry_q, digit_carry_flag_q, zero_q, flush_q;
  logic [13:0] instr;
  logic [7:0] file_rdata, file_wdata_q, work_q;
  logic [6:0] file_addr_q;
  logic [14:0] program_counter_q, epc;
  int failures = 0;
  int checks_done = 0;
  // Rows: opcode, work after, {carry, digit carry, zero, write}, write data
  abx_row_t rows [15] = '{'{14'h0704, 8'h04, 4'h0, 8'h00}, '{14'h070C, 8'h10, 4'h4, 8'h00},
    '{14'h0770, 8'h80, 4'h0, 8'h00}, '{14'h077E, 8'hFE, 4'h0, 8'h00},
    '{14'h3D02, 8'h00, 4'hE, 8'h00}, '{14'h3D02, 8'h03, 4'h0, 8'h00},
    '{14'h3743, 8'hE1, 4'h8, 8'h00}, '{14'h3700, 8'h00, 4'h2, 8'h00},
    '{14'h3D01, 8'h81, 4'h0, 8'h00}, '{14'h0790, 8'h81, 4'h1, 8'h91},
    '{14'h3710, 8'hC8, 4'h8, 8'h00}, '{14'h1390, 8'hC8, 4'h9, 8'h11},
    '{14'h1010, 8'hC8, 4'h9, 8'h10}, '{14'h3D85, 8'hC8, 4'h9, 8'h4E},
    '{14'h3783, 8'hC8, 4'h9, 8'hC1}};
  abx_exec dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr(instr),
    .instr_valid(instr_valid), .file_rdata(file_rdata), .file_addr_q(file_addr_q),
    .file_wdata_q(file_wdata_q), .file_we_q(file_we_q), .work_q(work_q),
    .carry_q(carry_q), .digit_carry_flag_q(digit_carry_flag_q), .zero_q(zero_q),
    .program_counter_q(program_counter_q), .flush_q(flush_q));
  abx_file_model fm (.sys_clk(sys_clk), .rd_addr(instr[6:0]), .wr_addr(file_addr_q),
    .wr_data(file_wdata_q), .wr_en(file_we_q), .rd_data(file_rdata));
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // One instruction per cycle; the PC expectation advances with it
  task automatic exec(input logic [13:0] op);
    instr = op;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    epc = epc + 15'h0001;
  endtask
  // Closing report
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    #100us;
    failures++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    instr = 14'h0000;
    instr_valid = 1'b0;
    epc = 15'h0000;
    repeat (6) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    foreach (rows[i])
    begin
      exec(rows[i].op);
      `CHK(work_q, rows[i].w)
      `CHK({carry_q, digit_carry_flag_q, zero_q, file_we_q}, rows[i].f)
      if (rows[i].f[0]) `CHK({file_addr_q, file_wdata_q}, {rows[i].op[6:0], rows[i].wd})
      `CHK({flush_q, program_counter_q}, {1'b0, epc})
    end
    $display("Test table rows done");
    exec(14'h1810);
    `CHK(flush_q, 1'b1)
    exec(14'h0704);
    `CHK({work_q, flush_q, program_counter_q}, {8'hC8, 1'b0, epc})
    exec(14'h1A10);
    `CHK({flush_q, carry_q}, 2'b01)
    exec(14'h0704);
    `CHK({work_q, carry_q}, {8'hCC, 1'b0})
    $display("Test skip done");
    // Offset -256 then +255: both ends of the signed range
    exec(14'h3300);
    epc = epc + 15'h7F00;
    `CHK({flush_q, program_counter_q, carry_q, zero_q}, {1'b1, epc, 2'b00})
    exec(14'h0704);
    `CHK({flush_q, work_q, program_counter_q}, {1'b0, 8'hCC, epc})
    exec(14'h32FF);
    epc = epc + 15'h00FF;
    `CHK({flush_q, program_counter_q}, {1'b1, epc})
    $display("Test branch done");
    instr_valid = 1'b0;
    sys_rst = 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK({work_q, carry_q, digit_carry_flag_q, zero_q, program_counter_q, flush_q}, 27'h0)
    `CHK({file_we_q, file_addr_q, file_wdata_q}, 16'h0000)
    $display("Test reset done");
    // Release in mid-run: an idle edge first, then work resumes from zero
    sys_rst = 1'b0;
    epc = 15'h0000;
    instr = 14'h0704;
    @(posedge sys_clk);
    #1;
    `CHK({work_q, program_counter_q, file_we_q}, 24'h000000)
    exec(14'h0704);
    `CHK({work_q, carry_q, zero_q, program_counter_q}, {8'h04, 2'h0, epc})
    exec(14'h0000);
    `CHK({work_q, file_we_q, flush_q, program_counter_q}, {8'h04, 2'h0, epc})
    $display("Test reset release done");
    give_verdict();
  end
endmodule
